// *** bench/calendar_clock_rate_trim_bench.sv ***
`timescale 1ns/1ps
module calendar_clock_rate_trim_bench;
    logic        mclk, rst_b, xtal, hsel, hwrite, hready, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, s;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [6:0]  trim;
    int          error_cnt, total_checks;
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // The crystal runs free at a fifth of the bus clock, its edges kept off the bus edges.
    initial begin
        xtal = 1'b0;
        #25;
        forever #250 xtal = ~xtal;
    end
    cct_top cct_top_i (.MCLK(mclk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
        .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .XTAL_CLK(xtal),
        .LOAD_TRIM(trim), .ONE_SEC_IRQ(irq));
    cct_cpu cct_cpu_i (.clk(mclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] ew);
        logic [31:0] d;
        logic [31:0] ws;
        cct_cpu_i.xfer(1'b0, a, 32'h0, d, ws);
        chk("read data", e, d);
        chk("wait states", ew, ws);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic [31:0] ws;
        cct_cpu_i.xfer(1'b1, a, d, r, ws);
    endtask : wr
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        wrap_up();
    end
    initial begin
        rst_b = 1'b0;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("trim pin", 32'h40, {25'h0, trim});
        chk("irq pin", 32'h0, {31'h0, irq});
        cct_cpu_i.sec_rd(s);
        chk("seconds", 32'h0, s);
        rd(cct_pkg::OFF_COARSE, 32'h10000, 32'h0);
        rd(cct_pkg::OFF_FINE, 32'h0, 32'h0);
        rd(cct_pkg::OFF_WDAY, 32'h1, 32'h1);
        rd(cct_pkg::OFF_MDAY, 32'h1, 32'h1);
        rd(cct_pkg::OFF_MON, 32'h1, 32'h1);
        rd(cct_pkg::OFF_YEAR, 32'h0, 32'h1);
        // Minute writes are made while locked and must leave the counter alone.
        wr(cct_pkg::OFF_MIN, 32'h2A);
        cct_cpu_i.time_wr(cct_pkg::OFF_HOUR, 32'h05);
        wr(cct_pkg::OFF_MIN, 32'h2A);
        rd(cct_pkg::OFF_HOUR, 32'h0, 32'h1);
        cct_cpu_i.sec_rd(s);
        rd(cct_pkg::OFF_HOUR, 32'h5, 32'h1);
        rd(cct_pkg::OFF_MIN, 32'h0, 32'h1);
        cct_cpu_i.time_wr(cct_pkg::OFF_SEC, 32'h3B);
        cct_cpu_i.time_wr(cct_pkg::OFF_WDAY, 32'h03);
        cct_cpu_i.time_wr(cct_pkg::OFF_MDAY, 32'h1C);
        cct_cpu_i.time_wr(cct_pkg::OFF_MON, 32'h02);
        cct_cpu_i.time_wr(cct_pkg::OFF_YEAR, 32'h04);
        cct_cpu_i.sec_rd(s);
        chk("seconds", 32'h3B, s);
        rd(cct_pkg::OFF_WDAY, 32'h3, 32'h1);
        rd(cct_pkg::OFF_MDAY, 32'h1C, 32'h1);
        rd(cct_pkg::OFF_MON, 32'h2, 32'h1);
        rd(cct_pkg::OFF_YEAR, 32'h4, 32'h1);
        wr(cct_pkg::OFF_COARSE, 32'h10040);
        wr(cct_pkg::OFF_FINE, 32'h3);
        rd(cct_pkg::OFF_COARSE, 32'h10040, 32'h0);
        rd(cct_pkg::OFF_FINE, 32'h3, 32'h0);
        wr(cct_pkg::OFF_TRIM, 32'h3F);
        @(posedge mclk);
        chk("trim pin", 32'h3F, {25'h0, trim});
        rd(cct_pkg::OFF_TRIM, 32'h3F, 32'h0);
        wr(cct_pkg::OFF_CTRL, 32'h1);
        rd(cct_pkg::OFF_FRAC, 32'hFF, 32'h0);
        rd(cct_pkg::OFF_CTRL, 32'h0, 32'h0);
        // About 181 crystal edges: one step of 128 edges must have passed, not two.
        repeat (900) @(posedge mclk);
        rd(cct_pkg::OFF_FRAC, 32'hFE, 32'h0);
        wr(cct_pkg::OFF_CTRL, 32'h2);
        rd(cct_pkg::OFF_CTRL, 32'h2, 32'h0);
        wr(cct_pkg::OFF_STAT, 32'h1);
        rd(cct_pkg::OFF_STAT, 32'h0, 32'h0);
        wr(cct_pkg::OFF_STAT, 32'h0);
        rd(cct_pkg::OFF_STAT, 32'h0, 32'h0);
        chk("irq pin", 32'h0, {31'h0, irq});
        rd(8'h3C, 32'h0, 32'h0);
        chk("response", 32'h0, {31'h0, hresp});
        wrap_up();
    end
endmodule : calendar_clock_rate_trim_bench

// *** bench/cct_cpu.sv ***
`timescale 1ns/1ps
module cct_cpu (
    input  wire logic        clk,    // Bus clock.
    input  wire logic        hready, // Bus ready.
    input  wire logic [31:0] hrdata, // Read data.
    output logic             hsel,   // Slave select.
    output logic      [31:0] haddr,  // Byte address.
    output logic      [1:0]  htrans, // Transfer type.
    output logic             hwrite, // Write when high.
    output logic      [2:0]  hsize,  // Word size.
    output logic      [31:0] hwdata  // Write data.
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // Each phase is held until ready is sampled high; waits are counted for the caller.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic [31:0] ws);
        ws = 32'h0;
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) begin
            ws = ws + 32'h1;
            @(posedge clk);
        end
        rd = hrdata;
    endtask : xfer
    // The lock closes after every time write, so each one carries its own unlock.
    task automatic time_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic [31:0] ws;
        xfer(1'b1, cct_pkg::OFF_UNLOCK, 32'h0000_00A5, rd, ws);
        xfer(1'b1, a, d, rd, ws);
    endtask : time_wr
    // Seconds may move under a read, so it is repeated, at most twice, until two reads in a row agree.
    task automatic sec_rd(output logic [31:0] s);
        logic [31:0] p;
        logic [31:0] ws;
        xfer(1'b0, cct_pkg::OFF_SEC, 32'h0, p, ws);
        for (int i = 0; i < 2; i++) begin
            xfer(1'b0, cct_pkg::OFF_SEC, 32'h0, s, ws);
            if (s === p) break;
            p = s;
        end
    endtask : sec_rd
endmodule : cct_cpu

// *** design/cct_cal.sv ***
`timescale 1ns/1ps
module cct_cal (
    input wire logic clk,   // System clock.
    input wire logic rst_n, // Synchronised reset, active low.
    cct_if.cal       b      // Calendar side.
);
    logic [7:0] sec_q, min_q, hour_q, wday_q, mday_q, mon_q, year_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_q  <= cct_pkg::RST_SEC;
            min_q  <= cct_pkg::RST_SEC;
            hour_q <= cct_pkg::RST_SEC;
            wday_q <= cct_pkg::RST_WDAY;
            mday_q <= cct_pkg::RST_MDAY;
            mon_q  <= cct_pkg::RST_MON;
            year_q <= cct_pkg::RST_YEAR;
        end else if (b.wr_en) begin
            case (cct_pkg::cct_field_e'(b.wr_sel))
                cct_pkg::F_SEC:  sec_q  <= b.wr_data;
                cct_pkg::F_MIN:  min_q  <= b.wr_data;
                cct_pkg::F_HOUR: hour_q <= b.wr_data;
                cct_pkg::F_WDAY: wday_q <= b.wr_data;
                cct_pkg::F_MDAY: mday_q <= b.wr_data;
                cct_pkg::F_MON:  mon_q  <= b.wr_data;
                cct_pkg::F_YEAR: year_q <= b.wr_data;
                default: ;
            endcase
        end else if (b.sec_tick) begin
            if (sec_q != cct_pkg::SEC_MAX) begin
                sec_q <= sec_q + 8'h01;
            end else begin
                sec_q <= cct_pkg::RST_SEC;
                if (min_q != cct_pkg::SEC_MAX) begin
                    min_q <= min_q + 8'h01;
                end else begin
                    min_q <= cct_pkg::RST_SEC;
                    if (hour_q != cct_pkg::HOUR_MAX) begin
                        hour_q <= hour_q + 8'h01;
                    end else begin
                        hour_q <= cct_pkg::RST_SEC;
                        wday_q <= (wday_q == cct_pkg::WDAY_MAX) ? cct_pkg::RST_WDAY
                                                                : wday_q + 8'h01;
                        // Two-digit years: every fourth year is a leap year.
                        if (mday_q != cct_pkg::days_in(mon_q, year_q)) begin
                            mday_q <= mday_q + 8'h01;
                        end else begin
                            mday_q <= cct_pkg::RST_MDAY;
                            if (mon_q != cct_pkg::MON_MAX) begin
                                mon_q <= mon_q + 8'h01;
                            end else begin
                                mon_q  <= cct_pkg::RST_MON;
                                year_q <= (year_q == cct_pkg::YEAR_MAX) ? cct_pkg::RST_YEAR
                                                                        : year_q + 8'h01;
                            end
                        end
                    end
                end
            end
        end
    end

    assign b.sec  = sec_q;
    assign b.min  = min_q;
    assign b.hour = hour_q;
    assign b.wday = wday_q;
    assign b.mday = mday_q;
    assign b.mon  = mon_q;
    assign b.year = year_q;

    property p_leap;
        @(posedge clk) disable iff (!rst_n)
            b.sec_tick && !b.wr_en && mon_q == 8'h02 && mday_q == 8'h1C && year_q[1:0] == 2'h0
            && hour_q == 8'h17 && min_q == 8'h3B && sec_q == 8'h3B |=> mday_q == 8'h1D;
    endproperty
    a_leap: assert property (p_leap) else $error("Leap February did not reach 29.");

    property p_sec_wrap;
        @(posedge clk) disable iff (!rst_n)
            b.sec_tick && !b.wr_en && sec_q == 8'h3B |=> sec_q == 8'h00 && min_q != $past(min_q);
    endproperty
    a_sec_wrap: assert property (p_sec_wrap) else $error("Seconds did not carry.");
endmodule : cct_cal

// *** design/cct_tick.sv ***
`timescale 1ns/1ps
module cct_tick (
    input wire logic clk,   // System clock.
    input wire logic rst_n, // Synchronised reset, active low.
    input wire logic xtal,  // Crystal clock, sampled.
    cct_if.tmr       b      // Timing outputs.
);
    logic        x1_q, x2_q, x3_q, sec_q;
    logic [16:0] cnt_q, per_q;
    logic [2:0]  rem_q;
    logic [6:0]  pre_q;
    logic [7:0]  frac_q;
    logic [19:0] sum;
    logic        tick, bound;

    // The crystal is unrelated to the system clock, so edges are taken only from the second and third stages.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            x1_q <= 1'b0;
            x2_q <= 1'b0;
            x3_q <= 1'b0;
        end else begin
            x1_q <= xtal;
            x2_q <= x1_q;
            x3_q <= x2_q;
        end
    end

    assign tick  = x2_q & ~x3_q;
    assign bound = tick && (cnt_q == per_q - 17'h00001);
    // Eight-second value carries a 3-bit remainder, so fractional cycles are spread out.
    assign sum   = {1'b0, b.rate_n} + {17'h00000, rem_q};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 17'h00000;
            per_q <= cct_pkg::RST_PERIOD;
            rem_q <= 3'h0;
            sec_q <= 1'b0;
        end else begin
            sec_q <= bound;
            if (bound) begin
                cnt_q <= 17'h00000;
                per_q <= sum[19:3];
                rem_q <= sum[2:0];
            end else if (tick) begin
                cnt_q <= cnt_q + 17'h00001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q  <= 7'h00;
            frac_q <= cct_pkg::FRAC_FULL;
        end else if (bound || b.frac_restart) begin
            pre_q  <= 7'h00;
            frac_q <= cct_pkg::FRAC_FULL;
        end else if (tick) begin
            pre_q <= pre_q + 7'h01;
            if (pre_q == cct_pkg::FRAC_PRE && frac_q != 8'h00) begin
                frac_q <= frac_q - 8'h01;
            end
        end
    end

    assign b.sec_tick = sec_q;
    assign b.frac     = frac_q;

    // The first edge after reset is judged against a cleared stage, so it is left out.
    property p_sync_edge;
        @(posedge clk) disable iff (!rst_n)
            tick && $past(rst_n, 3) |-> $past(xtal, 2) && !$past(xtal, 3);
    endproperty
    a_sync_edge: assert property (p_sync_edge) else $error("Edge not from synced crystal.");

    property p_frac_reload;
        @(posedge clk) disable iff (!rst_n) b.sec_tick |-> b.frac == 8'hFF && cnt_q == 17'h0;
    endproperty
    a_frac_reload: assert property (p_frac_reload) else $error("Boundary did not reload.");
endmodule : cct_tick

// *** design/cct_top.sv ***
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module cct_top (
    input  wire logic        MCLK,        // System clock, 10 MHz.
    input  wire logic        RST_B,       // Asynchronous reset, active low.
    input  wire logic        HSEL,        // Slave select.
    input  wire logic [31:0] HADDR,       // Byte address.
    input  wire logic [1:0]  HTRANS,      // Transfer type.
    input  wire logic        HWRITE,      // Write when high.
    input  wire logic [2:0]  HSIZE,       // Transfer size, word only.
    input  wire logic [31:0] HWDATA,      // Write data.
    input  wire logic        HREADY,      // Bus ready in.
    output logic      [31:0] HRDATA,      // Read data.
    output logic             HREADYOUT,   // Slave ready.
    output logic             HRESP,       // Always OKAY.
    input  wire logic        XTAL_CLK,    // Crystal time clock.
    output logic      [6:0]  LOAD_TRIM,   // Crystal load trim code.
    output logic             ONE_SEC_IRQ  // One-second interrupt request.
);
    logic        rst_s1_q, rst_n;
    logic        acc, rd_cal, do_wr, time_wr;
    logic        wr_q, wait_q, unlock_q;
    logic [7:0]  wa_q;
    logic [31:0] rd_d, rdata_q;
    logic [16:0] coarse_q;
    logic [1:0]  fine_q;
    logic [6:0]  trim_q;
    logic        en_q, flag_q, flag_clr;
    logic [7:0]  snap_min_q, snap_hour_q, snap_wday_q;
    logic [7:0]  snap_mday_q, snap_mon_q, snap_year_q;

    cct_if bus_if ();

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    cct_tick cct_tick_i (
        .clk   (MCLK),
        .rst_n (rst_n),
        .xtal  (XTAL_CLK),
        .b     (bus_if.tmr)
    );

    cct_cal cct_cal_i (
        .clk   (MCLK),
        .rst_n (rst_n),
        .b     (bus_if.cal)
    );

    assign acc     = HSEL && HTRANS[1] && HREADY;
    assign rd_cal  = acc && !HWRITE && HADDR[1:0] == 2'b00 && HADDR[7:0] <= cct_pkg::OFF_YEAR;
    assign do_wr   = wr_q;
    assign time_wr = do_wr && wa_q <= cct_pkg::OFF_YEAR;

    // Address phase capture; writes complete in their data phase with no wait.
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            wr_q   <= 1'b0;
            wa_q   <= 8'h00;
            wait_q <= 1'b0;
        end else begin
            wr_q   <= acc && HWRITE;
            wait_q <= rd_cal;
            if (acc) begin
                wa_q <= HADDR[7:0];
            end
        end
    end

    assign HREADYOUT = !wait_q;
    assign HRESP     = 1'b0;

    always_comb begin
        rd_d = 32'h00000000;
        case (HADDR[7:0])
            cct_pkg::OFF_SEC:    rd_d = {24'h000000, bus_if.sec};
            cct_pkg::OFF_MIN:    rd_d = {24'h000000, snap_min_q};
            cct_pkg::OFF_HOUR:   rd_d = {24'h000000, snap_hour_q};
            cct_pkg::OFF_WDAY:   rd_d = {24'h000000, snap_wday_q};
            cct_pkg::OFF_MDAY:   rd_d = {24'h000000, snap_mday_q};
            cct_pkg::OFF_MON:    rd_d = {24'h000000, snap_mon_q};
            cct_pkg::OFF_YEAR:   rd_d = {24'h000000, snap_year_q};
            cct_pkg::OFF_TRIM:   rd_d = {25'h0000000, trim_q};
            cct_pkg::OFF_COARSE: rd_d = {15'h0000, coarse_q};
            cct_pkg::OFF_FINE:   rd_d = {30'h00000000, fine_q};
            cct_pkg::OFF_FRAC:   rd_d = {24'h000000, bus_if.frac};
            cct_pkg::OFF_CTRL:   rd_d[cct_pkg::CTRL_ENABLE_BIT] = en_q;
            cct_pkg::OFF_STAT:   rd_d[cct_pkg::STAT_FLAG_BIT] = flag_q;
            default:             rd_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h00000000;
        end else if (acc && !HWRITE) begin
            rdata_q <= rd_d;
        end
    end

    assign HRDATA = rdata_q;

    // A seconds read freezes the rest, so software can check consistency by rereading.
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            snap_min_q  <= cct_pkg::RST_SEC;
            snap_hour_q <= cct_pkg::RST_SEC;
            snap_wday_q <= cct_pkg::RST_WDAY;
            snap_mday_q <= cct_pkg::RST_MDAY;
            snap_mon_q  <= cct_pkg::RST_MON;
            snap_year_q <= cct_pkg::RST_YEAR;
        end else if (acc && !HWRITE && HADDR[7:0] == cct_pkg::OFF_SEC) begin
            snap_min_q  <= bus_if.min;
            snap_hour_q <= bus_if.hour;
            snap_wday_q <= bus_if.wday;
            snap_mday_q <= bus_if.mday;
            snap_mon_q  <= bus_if.mon;
            snap_year_q <= bus_if.year;
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            unlock_q <= 1'b0;
        end else if (do_wr && wa_q == cct_pkg::OFF_UNLOCK) begin
            unlock_q <= 1'b1;
        end else if (time_wr) begin
            unlock_q <= 1'b0;
        end
    end

    assign bus_if.wr_en   = time_wr && unlock_q;
    assign bus_if.wr_sel  = wa_q[4:2];
    assign bus_if.wr_data = HWDATA[7:0];

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            coarse_q <= cct_pkg::RST_COARSE;
            fine_q   <= cct_pkg::RST_FINE;
        end else if (do_wr && wa_q == cct_pkg::OFF_COARSE) begin
            coarse_q <= HWDATA[16:0];
        end else if (do_wr && wa_q == cct_pkg::OFF_FINE) begin
            fine_q <= HWDATA[1:0];
        end
    end

    // The divider picks this up only at its own boundary.
    assign bus_if.rate_n = {coarse_q, fine_q};

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            trim_q <= cct_pkg::RST_TRIM;
        end else if (do_wr && wa_q == cct_pkg::OFF_TRIM) begin
            trim_q <= HWDATA[6:0];
        end
    end

    assign LOAD_TRIM = trim_q;

    assign bus_if.frac_restart = do_wr && wa_q == cct_pkg::OFF_CTRL
                                 && HWDATA[cct_pkg::CTRL_RESTART_BIT];

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= 1'b0;
        end else if (do_wr && wa_q == cct_pkg::OFF_CTRL) begin
            en_q <= HWDATA[cct_pkg::CTRL_ENABLE_BIT];
        end
    end

    // A byte mask of ones leaves the flag alone, so read-modify-write races are harmless.
    assign flag_clr = do_wr && wa_q == cct_pkg::OFF_STAT && !HWDATA[cct_pkg::STAT_FLAG_BIT];

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else if (bus_if.sec_tick) begin
            flag_q <= 1'b1;
        end else if (flag_clr) begin
            flag_q <= 1'b0;
        end
    end

    assign ONE_SEC_IRQ = flag_q && en_q;

    property p_wait;
        @(posedge MCLK) disable iff (!rst_n) rd_cal |=> !HREADYOUT ##1 HREADYOUT;
    endproperty
    a_wait: assert property (p_wait) else $error("Calendar read lacks one wait state.");

    property p_no_wait;
        @(posedge MCLK) disable iff (!rst_n) acc && !rd_cal |=> HREADYOUT;
    endproperty
    a_no_wait: assert property (p_no_wait) else $error("Unexpected wait state.");

    property p_snap;
        @(posedge MCLK) disable iff (!rst_n)
            acc && !HWRITE && HADDR[7:0] == 8'h00
            |=> snap_min_q == $past(bus_if.min) && snap_year_q == $past(bus_if.year);
    endproperty
    a_snap: assert property (p_snap) else $error("Seconds read did not refresh.");

    property p_locked;
        @(posedge MCLK) disable iff (!rst_n)
            time_wr && !unlock_q && !bus_if.sec_tick
            |=> $stable(bus_if.sec) && $stable(bus_if.min) && $stable(bus_if.hour);
    endproperty
    a_locked: assert property (p_locked) else $error("Locked time write accepted.");

    property p_relock;
        @(posedge MCLK) disable iff (!rst_n) bus_if.wr_en |=> !unlock_q ##1 !bus_if.wr_en;
    endproperty
    a_relock: assert property (p_relock) else $error("Unlock survived a time write.");

    property p_flag_set;
        @(posedge MCLK) disable iff (!rst_n) bus_if.sec_tick |=> flag_q;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("One-second flag lost.");

    property p_flag_hold;
        @(posedge MCLK) disable iff (!rst_n)
            flag_q && !flag_clr |=> flag_q;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("Flag cleared without zero.");

    property p_irq;
        @(posedge MCLK) disable iff (!rst_n)
            bus_if.sec_tick && en_q && !(do_wr && wa_q == cct_pkg::OFF_CTRL) |=> ONE_SEC_IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("Enabled event gave no request.");

    property p_trim;
        @(posedge MCLK) disable iff (!rst_n)
            do_wr && wa_q == 8'h20 |=> LOAD_TRIM == $past(HWDATA[6:0]);
    endproperty
    a_trim: assert property (p_trim) else $error("Trim write not applied.");

    property p_rate_hold;
        @(posedge MCLK) disable iff (!rst_n)
            !(do_wr && (wa_q == 8'h24 || wa_q == 8'h28)) |=> $stable(bus_if.rate_n);
    endproperty
    a_rate_hold: assert property (p_rate_hold) else $error("Rate changed unwritten.");
endmodule : cct_top

// *** shared/cct_if.sv ***
`timescale 1ns/1ps
interface cct_if;
    logic        sec_tick;
    logic [7:0]  frac;
    logic [18:0] rate_n;
    logic        frac_restart;
    logic        wr_en;
    logic [2:0]  wr_sel;
    logic [7:0]  wr_data;
    logic [7:0]  sec, min, hour, wday, mday, mon, year;
    modport tmr (output sec_tick, frac, input rate_n, frac_restart);
    modport cal (input sec_tick, wr_en, wr_sel, wr_data,
                 output sec, min, hour, wday, mday, mon, year);
    modport ctl (input sec_tick, frac, sec, min, hour, wday, mday, mon, year,
                 output rate_n, frac_restart, wr_en, wr_sel, wr_data);
endinterface : cct_if

// *** shared/cct_pkg.sv ***
package cct_pkg;
    // Register byte offsets, one aligned word each.
    localparam logic [7:0] OFF_SEC    = 8'h00;
    localparam logic [7:0] OFF_MIN    = 8'h04;
    localparam logic [7:0] OFF_HOUR   = 8'h08;
    localparam logic [7:0] OFF_WDAY   = 8'h0C;
    localparam logic [7:0] OFF_MDAY   = 8'h10;
    localparam logic [7:0] OFF_MON    = 8'h14;
    localparam logic [7:0] OFF_YEAR   = 8'h18;
    localparam logic [7:0] OFF_UNLOCK = 8'h1C;
    localparam logic [7:0] OFF_TRIM   = 8'h20;
    localparam logic [7:0] OFF_COARSE = 8'h24;
    localparam logic [7:0] OFF_FINE   = 8'h28;
    localparam logic [7:0] OFF_FRAC   = 8'h2C;
    localparam logic [7:0] OFF_CTRL   = 8'h30;
    localparam logic [7:0] OFF_STAT   = 8'h34;
    // Field positions.
    localparam int CTRL_RESTART_BIT = 0;
    localparam int CTRL_ENABLE_BIT  = 1;
    localparam int STAT_FLAG_BIT    = 0;
    // Reset values.
    localparam logic [16:0] RST_COARSE = 17'h10000;
    localparam logic [1:0]  RST_FINE   = 2'h0;
    localparam logic [6:0]  RST_TRIM   = 7'h40;
    localparam logic [16:0] RST_PERIOD = 17'h08000;
    localparam logic [7:0]  RST_SEC    = 8'h00;
    localparam logic [7:0]  RST_WDAY   = 8'h01;
    localparam logic [7:0]  RST_MDAY   = 8'h01;
    localparam logic [7:0]  RST_MON    = 8'h01;
    localparam logic [7:0]  RST_YEAR   = 8'h00;
    // Counter limits and timing counts.
    localparam logic [7:0]  SEC_MAX    = 8'h3B;
    localparam logic [7:0]  HOUR_MAX   = 8'h17;
    localparam logic [7:0]  WDAY_MAX   = 8'h07;
    localparam logic [7:0]  MON_MAX    = 8'h0C;
    localparam logic [7:0]  YEAR_MAX   = 8'h63;
    localparam logic [6:0]  FRAC_PRE   = 7'h7F;
    localparam logic [7:0]  FRAC_FULL  = 8'hFF;

    typedef enum logic [2:0] {
        F_SEC  = 3'b000,
        F_MIN  = 3'b001,
        F_HOUR = 3'b010,
        F_WDAY = 3'b011,
        F_MDAY = 3'b100,
        F_MON  = 3'b101,
        F_YEAR = 3'b110
    } cct_field_e;

    function automatic logic [7:0] days_in(input logic [7:0] mon, input logic [7:0] yr);
        case (mon)
            8'h02: days_in = (yr[1:0] == 2'h0) ? 8'h1D : 8'h1C;
            8'h04, 8'h06, 8'h09, 8'h0B: days_in = 8'h1E;
            default: days_in = 8'h1F;
        endcase
    endfunction : days_in
endpackage : cct_pkg
